// *** cross_trigger_sync_matrix_tb.sv ***
`default_nettype none

module cross_trigger_sync_matrix_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ctsm_pkg::*;

   // ---------------------------------------------
   // Signals
   // ---------------------------------------------
   localparam ctsm_conn_t cn = CTSM_CONN_NONE;
   localparam ctsm_conn_t cd = CTSM_CONN_DRIVE;
   localparam ctsm_conn_t cr = CTSM_CONN_RECEIVE;
   localparam ctsm_cmd_t c_sync = 3'h4;
   localparam ctsm_cmd_t c_toe = 3'h2;
   localparam ctsm_cmd_t c_tst = 3'h1;
   localparam int k_brk = 9, k_run = 8, k_trb = 7, k_exo = 6, k_ear = 5, k_xar = 4, k_toe = 3, k_coe = 2, k_roe = 1;
   logic clk, reset_n, armed, on;
   ctsm_run_cfg_t run_cfg;
   ctsm_line_cfg_t [1:0] line;
   ctsm_cmd_t cmd;
   ctsm_events_t ev;
   ctsm_ctl_t ctl;
   logic trig_n_o, trig_oe, rdy_o, rdy_oe, exe_o, exe_oe, coax_o, coax_oe;
   logic trig_n, rdy, exe_n, coax, p_trig, p_hold, p_exec, p_coax;
   logic [7:0] cnt [10];
   int num_errors = 0, compares = 0, cycles = 0;
   wire logic [9:0] sig;

   assign sig = {ctl.break_req, ctl.run_req, ctl.trace_begin, exe_oe, ctl.emu_arm, ctl.ext_arm,
                 trig_oe, coax_oe, rdy_oe, armed};

   ctsm_matrix u_ctsm_matrix (.i_core_clk(clk), .i_reset_n(reset_n), .i_run_cfg(run_cfg),
      .i_line_cfg(line), .i_cmd(cmd), .i_ev(ev), .o_ctl(ctl), .o_trace_armed(armed),
      .i_cmb_trig_n(trig_n), .o_cmb_trig_n(trig_n_o), .o_cmb_trig_oe(trig_oe),
      .i_cmb_ready(rdy), .o_cmb_ready(rdy_o), .o_cmb_ready_oe(rdy_oe),
      .i_cmb_exec_n(exe_n), .o_cmb_exec_n(exe_o), .o_cmb_exec_oe(exe_oe),
      .i_coax(coax), .o_coax(coax_o), .o_coax_oe(coax_oe));

   ctsm_peer_model u_ctsm_peer_model (.i_trig_oe(trig_oe), .i_ready_oe(rdy_oe), .i_exec_oe(exe_oe),
      .i_coax(coax_o), .i_coax_oe(coax_oe), .i_peer_trig(p_trig), .i_peer_hold(p_hold),
      .i_peer_exec(p_exec), .i_peer_coax(p_coax), .o_trig_n(trig_n), .o_ready(rdy),
      .o_exec_n(exe_n), .o_coax(coax));

   // ---------------------------------------------
   // Clock, monitor, timeout
   // ---------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Counted on the falling edge, where outputs have settled
   always @(negedge clk) begin
      if (on) begin
         for (int k = 0; k < 10; k++) begin
            cnt[k] = cnt[k] + {7'h00, sig[k]};
         end
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         give_verdict();
      end
   end

   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic give_verdict;
      $display("counts: %0d compares, %0d mismatches", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic cc(input string what, input int k, input logic [7:0] exp);
      chk(what, exp, cnt[k]);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic open_win;
      for (int k = 0; k < 10; k++) begin
         cnt[k] = 8'h00;
      end
      on = 1'b1;
   endtask

   // One-cycle command, a free edge after it
   task automatic go(input ctsm_cmd_t c);
      cmd <= c;
      cyc(1);
      cmd <= 3'h0;
      cyc(1);
   endtask

   function automatic ctsm_line_cfg_t lc(ctsm_conn_t c, ctsm_conn_t x, ctsm_conn_t e, ctsm_conn_t a, logic b);
      lc = '{c, x, e, a, b};
   endfunction

   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial begin
      reset_n = 1'b0;
      run_cfg = 3'h0;
      line = '0;
      cmd = 3'h0;
      ev = 4'h0;
      {p_trig, p_hold, p_exec, p_coax, on} = 5'h00;
      cyc(6);
      reset_n <= 1'b1;
      open_win();
      cyc(4);
      for (int k = 0; k < 10; k++) cc("reset output", k, 8'h00);
      chk("open drain data", 8'h00, {4'h0, coax_o, trig_n_o, rdy_o, exe_o});
      $display("test reset done");

      for (int i = 0; i < 3; i++) begin
         run_cfg <= '{i == 1, 1'b0, 1'b0};
         line[0] <= (i < 2) ? lc(cr, cr, cn, cn, 1'b0) : '0;
         cyc(8);
         open_win();
         ev.emu_trig <= 1'b1;
         cyc(3);
         ev.emu_trig <= 1'b0;
         cyc(6);
         cc("break line a", k_brk, 8'h03);
         cc("bus trigger out", k_toe, (i < 2) ? 8'h03 : 8'h00);
         cc("coax out", k_coe, (i < 2) ? 8'h03 : 8'h00);
      end
      $display("test line a routing done");

      run_cfg <= 3'h1;
      line[0] <= '0;
      for (int i = 0; i < 2; i++) begin
         line[1] <= (i != 0) ? lc(cn, cd, cr, cr, 1'b0) : lc(cd, cn, cr, cr, 1'b0);
         cyc(8);
         open_win();
         if (i != 0) p_coax <= 1'b1;
         else p_trig <= 1'b1;
         cyc(4);
         p_coax <= 1'b0;
         p_trig <= 1'b0;
         cyc(8);
         cc("emu arm", k_ear, (i != 0) ? 8'h01 : 8'h04);
         cc("ext arm", k_xar, (i != 0) ? 8'h01 : 8'h04);
         cc("no break via b", k_brk, 8'h00);
      end
      $display("test arming done");

      for (int i = 0; i < 4; i++) begin
         run_cfg.ext_indep <= (i != 0);
         line[1] <= (i == 2) ? lc(cd, cn, cn, cn, 1'b1) : lc(cn, cn, cn, cd, 1'b1);
         line[0] <= (i == 3) ? lc(cn, cd, cn, cn, 1'b0) : '0;
         cyc(8);
         open_win();
         ev.ext_trig <= (i < 2);
         p_trig <= (i == 2);
         p_coax <= (i == 3);
         cyc(3);
         ev.ext_trig <= 1'b0;
         p_trig <= 1'b0;
         p_coax <= 1'b0;
         cyc(8);
         cc("break source", k_brk, (i == 3) ? 8'h01 : (i != 0) ? 8'h03 : 8'h00);
      end
      $display("test break sources done");

      line <= '0;
      for (int i = 0; i < 3; i++) begin
         run_cfg <= '{i != 0, 1'b1, 1'b0};
         cyc(8);
         open_win();
         if (i != 0) go(c_toe);
         if (i == 2) go(c_tst);
         chk("trace armed", 8'(i == 1), {7'h00, armed});
         go(c_sync);
         cyc(14);
         cc("exec pulse", k_exo, 8'h05);
         cc("run start", k_run, 8'(i != 0));
         cc("trace begin", k_trb, 8'(i == 1));
         chk("run from start", 8'h01, {7'h00, ctl.run_from_start});
      end
      $display("test sync start done");

      for (int i = 0; i < 3; i++) begin
         run_cfg <= '{i != 0, 1'b0, 1'b0};
         cyc(8);
         open_win();
         p_hold <= 1'b1;
         cyc(3);
         p_hold <= 1'b0;
         cyc(8);
         cc("peer break", k_brk, 8'(i != 0));
         open_win();
         if (i < 2) ev.emu_broken <= 1'b1;
         else ev.emu_in_reset <= 1'b1;
         cyc(4);
         ev.emu_broken <= 1'b0;
         ev.emu_in_reset <= 1'b0;
         cyc(4);
         cc("ready hold", k_roe, (i != 0) ? 8'h04 : 8'h00);
      end
      $display("test ready done");
      give_verdict();
   end
endmodule

`default_nettype wire

// *** ctsm_consts.svh ***
`ifndef CTSM_CONSTS_SVH
`define CTSM_CONSTS_SVH

// ---------------------------------------------
// Clock and timing
// ---------------------------------------------
`define CTSM_CLK_PERIOD_NS 20
`define CTSM_EXEC_PULSE_NS 100

// ---------------------------------------------
// Coordination bus sizing
// ---------------------------------------------
`define CTSM_MAX_PEERS 32
`define CTSM_NUM_LINES 2
`define CTSM_LINE_A 0
`define CTSM_LINE_B 1

// ---------------------------------------------
// Synchroniser bit positions and reset levels
// ---------------------------------------------
`define CTSM_SYNC_W 4
`define CTSM_SYNC_TRIG_N 0
`define CTSM_SYNC_READY 1
`define CTSM_SYNC_EXEC_N 2
`define CTSM_SYNC_COAX 3
`define CTSM_SYNC_RST 4'h7
`define CTSM_EXEC_CNT_W 4
`define CTSM_EXEC_CNT_ZERO 4'h0
`define CTSM_EXEC_CNT_ONE 4'h1

`endif

// *** ctsm_matrix.sv ***
// Overview of operation
// - With run interaction on, execute strobe starts emulator from PC or start address.
// - Sync start pulses execute line once, even with run interaction off.
// - Enabled emulator breaks when any enabled peer breaks (ready falls).
// - Run interaction off: ready line is ignored; execute only begins an armed trace.
// - Trace-on-execute holds trace, begins it on execute strobe.
// - Ordinary trace start clears trace-on-execute; execute then ignored by analyzer.
// - Run interaction setting never affects trigger line routing.
// - Line A always driven by emulation analyzer, always feeds break input.
// - Either line can send analyzer triggers to bus trigger or coax port.
// - Either line can feed break from bus trigger, coax, or analyzers.
// - Only line B can arm analyzers from bus trigger or coax.
// - With several break sources, whichever comes first breaks.
// - Each line connection can be set to none individually, except line A's analyzer drive and break input.
// - External analyzer joins line B only when configured independent.
// - Coax trigger is a rising edge, driven and received.
// - Coax port is shared by several drivers (open emitter).
// - Coordination bus starts and stops up to 32 emulators together.
// - Ready is wired AND; held false while broken or in reset, with run interaction on.
// - Bus trigger is low-true and level-sensitive; drive or receive.
// - Execute is low-true; run from address once ready returns true.
`include "ctsm_consts.svh"
`default_nettype none

module ctsm_matrix (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // Configuration and commands
   input wire ctsm_pkg::ctsm_run_cfg_t i_run_cfg,
   input wire ctsm_pkg::ctsm_line_cfg_t [`CTSM_NUM_LINES-1:0] i_line_cfg,
   input wire ctsm_pkg::ctsm_cmd_t i_cmd,
   input wire ctsm_pkg::ctsm_events_t i_ev,
   // Emulator and analyzer controls
   output ctsm_pkg::ctsm_ctl_t o_ctl,
   output logic o_trace_armed,
   // Coordination bus trigger, open drain, low true
   input wire logic i_cmb_trig_n,
   output logic o_cmb_trig_n,
   output logic o_cmb_trig_oe,
   // Coordination bus ready, open drain
   input wire logic i_cmb_ready,
   output logic o_cmb_ready,
   output logic o_cmb_ready_oe,
   // Coordination bus execute, open drain, low true
   input wire logic i_cmb_exec_n,
   output logic o_cmb_exec_n,
   output logic o_cmb_exec_oe,
   // Coaxial trigger port, open emitter
   input wire logic i_coax,
   output logic o_coax,
   output logic o_coax_oe
);
   import ctsm_pkg::*;

   // ---------------------------------------------
   // Timing
   // ---------------------------------------------
   // Least pulse time, rounded up to whole cycles
   localparam int EXEC_CYC_I = (`CTSM_EXEC_PULSE_NS + `CTSM_CLK_PERIOD_NS - 1) / `CTSM_CLK_PERIOD_NS;
   localparam logic [`CTSM_EXEC_CNT_W-1:0] EXEC_CYC = EXEC_CYC_I[`CTSM_EXEC_CNT_W-1:0];
   // Ready is a wired AND across at most this many units
   localparam int MAX_PEERS = `CTSM_MAX_PEERS;

   // ---------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------
   logic [`CTSM_SYNC_W-1:0] pins_s;
   logic trig_rx;
   logic ready_s;
   logic exec_n_s;
   logic coax_s;
   logic ready_prev;
   logic exec_prev_n;
   logic coax_prev;
   logic exec_fall;
   logic coax_rise;
   logic ready_fall;

   ctsm_sync u_sync (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .i_async({i_coax, i_cmb_exec_n, i_cmb_ready, i_cmb_trig_n}),
      .o_sync(pins_s)
   );

   assign trig_rx = ~pins_s[`CTSM_SYNC_TRIG_N];
   assign ready_s = pins_s[`CTSM_SYNC_READY];
   assign exec_n_s = pins_s[`CTSM_SYNC_EXEC_N];
   assign coax_s = pins_s[`CTSM_SYNC_COAX];

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         ready_prev <= 1'b1;
         exec_prev_n <= 1'b1;
         coax_prev <= 1'b0;
      end else begin
         ready_prev <= ready_s;
         exec_prev_n <= exec_n_s;
         coax_prev <= coax_s;
      end
   end

   assign exec_fall = exec_prev_n & ~exec_n_s;
   assign coax_rise = coax_s & ~coax_prev;
   assign ready_fall = ready_prev & ~ready_s;

   // ---------------------------------------------
   // Trigger line matrix
   // ---------------------------------------------
   // Routing ignores run interaction entirely
   logic [`CTSM_NUM_LINES-1:0] line;
   logic [`CTSM_NUM_LINES-1:0] to_coordination_bus_trigger;
   logic [`CTSM_NUM_LINES-1:0] to_coax;
   logic [`CTSM_NUM_LINES-1:0] to_break;
   logic [`CTSM_NUM_LINES-1:0] to_emu_arm;
   logic [`CTSM_NUM_LINES-1:0] to_ext_arm;

   for (genvar i = 0; i < `CTSM_NUM_LINES; i++) begin : g_line
      logic emu_drv;
      logic emu_rcv;
      logic ext_drv;
      logic ext_rcv;
      logic brk_rcv;
      logic ext_ok;
      // Line A is hard wired analyzer-to-break
      if (i == `CTSM_LINE_A) begin : g_a
         assign emu_drv = 1'b1;
         assign emu_rcv = 1'b0;
         assign brk_rcv = 1'b1;
         assign ext_ok = 1'b0;
      end else begin : g_b
         assign emu_drv = i_line_cfg[i].emu_ana == CTSM_CONN_DRIVE;
         assign emu_rcv = i_line_cfg[i].emu_ana == CTSM_CONN_RECEIVE;
         assign brk_rcv = i_line_cfg[i].break_rcv;
         assign ext_ok = i_run_cfg.ext_indep;
      end
      assign ext_drv = ext_ok && i_line_cfg[i].ext_ana == CTSM_CONN_DRIVE;
      assign ext_rcv = ext_ok && i_line_cfg[i].ext_ana == CTSM_CONN_RECEIVE;
      // OR of every enabled source; NONE drops a party
      assign line[i] = (emu_drv & i_ev.emu_trig) | (ext_drv & i_ev.ext_trig)
                     | (i_line_cfg[i].coordination_bus_trigger == CTSM_CONN_DRIVE & trig_rx)
                     | (i_line_cfg[i].coax == CTSM_CONN_DRIVE & coax_rise);
      assign to_coordination_bus_trigger[i] = line[i] & (i_line_cfg[i].coordination_bus_trigger == CTSM_CONN_RECEIVE);
      assign to_coax[i] = line[i] & (i_line_cfg[i].coax == CTSM_CONN_RECEIVE);
      assign to_break[i] = line[i] & brk_rcv;
      assign to_emu_arm[i] = line[i] & emu_rcv;
      assign to_ext_arm[i] = line[i] & ext_rcv;
   end

   // ---------------------------------------------
   // Trigger outputs to pins
   // ---------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         o_cmb_trig_n <= 1'b0;
         o_cmb_trig_oe <= 1'b0;
         o_coax <= 1'b0;
         o_coax_oe <= 1'b0;
      end else begin
         o_cmb_trig_n <= 1'b0;
         o_cmb_trig_oe <= |to_coordination_bus_trigger;
         // Level out, so its rising edge marks the trigger
         o_coax <= |to_coax;
         // Drive only while high; others may share the line
         o_coax_oe <= |to_coax;
      end
   end

   // ---------------------------------------------
   // Ready line and peer break
   // ---------------------------------------------
   logic peer_break;

   // Own drive low would also drop ready, so only a running unit
   // treats a fall as a peer's break
   assign peer_break = i_run_cfg.run_enable & ready_fall
                     & ~i_ev.emu_broken & ~i_ev.emu_in_reset;

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         o_cmb_ready <= 1'b0;
         o_cmb_ready_oe <= 1'b0;
      end else begin
         o_cmb_ready <= 1'b0;
         o_cmb_ready_oe <= i_run_cfg.run_enable & (i_ev.emu_broken | i_ev.emu_in_reset);
      end
   end

   // ---------------------------------------------
   // Execute pulse generator
   // ---------------------------------------------
   logic [`CTSM_EXEC_CNT_W-1:0] exec_cnt;

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         exec_cnt <= `CTSM_EXEC_CNT_ZERO;
      end else if (exec_cnt != `CTSM_EXEC_CNT_ZERO) begin
         exec_cnt <= exec_cnt - 1'b1;
      end else if (i_cmd.sync_start) begin
         // Not gated by run interaction
         exec_cnt <= EXEC_CYC;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         o_cmb_exec_n <= 1'b0;
         o_cmb_exec_oe <= 1'b0;
      end else begin
         o_cmb_exec_n <= 1'b0;
         // Output is registered, so it stops one count early to keep the pulse length
         o_cmb_exec_oe <= (exec_cnt > `CTSM_EXEC_CNT_ONE)
                        || (i_cmd.sync_start && exec_cnt == `CTSM_EXEC_CNT_ZERO);
      end
   end

   // ---------------------------------------------
   // Synchronous run control
   // ---------------------------------------------
   ctsm_run_state_t run_state;
   logic next_run_req;

   assign next_run_req = run_state == CTSM_RUN_WAIT_READY && i_run_cfg.run_enable && ready_s;

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         run_state <= CTSM_RUN_IDLE;
      end else if (!i_run_cfg.run_enable) begin
         run_state <= CTSM_RUN_IDLE;
      end else begin
         unique case (run_state)
            CTSM_RUN_IDLE: begin
               if (exec_fall) begin
                  run_state <= CTSM_RUN_WAIT_READY;
               end
            end
            CTSM_RUN_WAIT_READY: begin
               if (ready_s) begin
                  run_state <= CTSM_RUN_IDLE;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------
   // Trace on execute
   // ---------------------------------------------
   logic trace_go;

   assign trace_go = o_trace_armed & exec_fall & ~i_cmd.trace_start;

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         o_trace_armed <= 1'b0;
      end else if (i_cmd.trace_start) begin
         // Later command wins over a same-cycle arm
         o_trace_armed <= 1'b0;
      end else if (i_cmd.trace_on_exec) begin
         o_trace_armed <= 1'b1;
      end else if (trace_go) begin
         o_trace_armed <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Control outputs
   // ---------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         o_ctl <= '0;
      end else begin
         // Any source, first to arrive, breaks
         o_ctl.break_req <= (|to_break) | peer_break;
         o_ctl.run_req <= next_run_req;
         o_ctl.run_from_start <= i_run_cfg.from_start;
         o_ctl.trace_begin <= trace_go;
         o_ctl.emu_arm <= to_emu_arm[`CTSM_LINE_B];
         o_ctl.ext_arm <= to_ext_arm[`CTSM_LINE_B];
      end
   end

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_reset_n);

   sequence s_exec_start;
      i_cmd.sync_start && exec_cnt == `CTSM_EXEC_CNT_ZERO;
   endsequence

   sequence s_exec_pulse;
      o_cmb_exec_oe [*5] ##1 !o_cmb_exec_oe;
   endsequence

   sequence s_wait_then_ready;
      run_state == CTSM_RUN_WAIT_READY && i_run_cfg.run_enable && ready_s;
   endsequence

   a_run_on_ready:
      assert property (s_wait_then_ready |=> o_ctl.run_req ##1 !o_ctl.run_req)
      else $error("run request missing after ready");

   a_exec_pulse_len:
      assert property (s_exec_start ##1 !i_cmd.sync_start |-> s_exec_pulse)
      else $error("execute pulse length wrong");

   a_peer_break:
      assert property ($fell(ready_s) && i_run_cfg.run_enable && !i_ev.emu_broken
                       && !i_ev.emu_in_reset |=> o_ctl.break_req)
      else $error("peer break not followed");

   a_disabled_ignore:
      assert property (!i_run_cfg.run_enable [*2] |-> !o_ctl.run_req)
      else $error("run while interaction disabled");

   a_trace_exec:
      assert property (o_trace_armed && exec_fall && !i_cmd.trace_start && !i_cmd.trace_on_exec
                       |=> o_ctl.trace_begin && !o_trace_armed)
      else $error("trace not begun on execute");

   a_trace_cancel:
      assert property (i_cmd.trace_start |=> !o_trace_armed ##0 !o_ctl.trace_begin)
      else $error("trace start did not clear arm");

   a_line_a_break:
      assert property (i_ev.emu_trig |=> o_ctl.break_req)
      else $error("analyzer trigger did not break");

   a_ready_hold:
      assert property (i_run_cfg.run_enable && i_ev.emu_broken |=> o_cmb_ready_oe)
      else $error("ready not held while broken");

   a_arm_line_b:
      assert property (o_ctl.emu_arm || o_ctl.ext_arm |-> $past(line[`CTSM_LINE_B]))
      else $error("arm without line B");

   a_coax_edge:
      assert property ($rose(coax_s) && i_line_cfg[`CTSM_LINE_A].coax == CTSM_CONN_DRIVE |=> o_ctl.break_req)
      else $error("coax edge did not break");

endmodule

`default_nettype wire

// *** ctsm_peer_model.sv ***
`default_nettype none

module ctsm_peer_model (
   // Design side pin drives
   input wire logic i_trig_oe,
   input wire logic i_ready_oe,
   input wire logic i_exec_oe,
   input wire logic i_coax,
   input wire logic i_coax_oe,
   // Peer requests from the bench
   input wire logic i_peer_trig,
   input wire logic i_peer_hold,
   input wire logic i_peer_exec,
   input wire logic i_peer_coax,
   // Resolved pin levels
   output logic o_trig_n,
   output logic o_ready,
   output logic o_exec_n,
   output logic o_coax
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------
   // Wired lines
   // ---------------------------------------------
   // Pull-ups restore idle once every party lets go
   assign o_trig_n = ~(i_trig_oe | i_peer_trig);
   // Peers break to a background monitor, seen here only as a ready hold
   // Peers never step, so none needs to drop run interaction mid-run
   assign o_ready = ~(i_ready_oe | i_peer_hold);
   assign o_exec_n = ~(i_exec_oe | i_peer_exec);
   // Open emitter, pull-down when nobody drives
   assign o_coax = (i_coax & i_coax_oe) | i_peer_coax;
endmodule

`default_nettype wire

// *** ctsm_pkg.sv ***
`default_nettype none

package ctsm_pkg;

   // ---------------------------------------------
   // Connection of one party to an internal line
   // ---------------------------------------------
   typedef enum logic [1:0] {
      CTSM_CONN_NONE,
      CTSM_CONN_DRIVE,
      CTSM_CONN_RECEIVE
   } ctsm_conn_t;

   typedef struct packed {
      ctsm_conn_t coordination_bus_trigger;
      ctsm_conn_t coax;
      ctsm_conn_t emu_ana;
      ctsm_conn_t ext_ana;
      logic break_rcv;
   } ctsm_line_cfg_t;

   typedef struct packed {
      logic run_enable;
      logic from_start;
      logic ext_indep;
   } ctsm_run_cfg_t;

   typedef struct packed {
      logic sync_start;
      logic trace_on_exec;
      logic trace_start;
   } ctsm_cmd_t;

   typedef struct packed {
      logic emu_trig;
      logic ext_trig;
      logic emu_broken;
      logic emu_in_reset;
   } ctsm_events_t;

   typedef struct packed {
      logic break_req;
      logic run_req;
      logic run_from_start;
      logic trace_begin;
      logic emu_arm;
      logic ext_arm;
   } ctsm_ctl_t;

   typedef enum logic {
      CTSM_RUN_IDLE,
      CTSM_RUN_WAIT_READY
   } ctsm_run_state_t;

endpackage

`default_nettype wire

// *** ctsm_sync.sv ***
`include "ctsm_consts.svh"
`default_nettype none

module ctsm_sync (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // Pin levels in, synced levels out
   input wire logic [`CTSM_SYNC_W-1:0] i_async,
   output logic [`CTSM_SYNC_W-1:0] o_sync
);
   import ctsm_pkg::*;

   // Stage one is read only by stage two
   logic [`CTSM_SYNC_W-1:0] meta;

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         meta <= `CTSM_SYNC_RST;
         o_sync <= `CTSM_SYNC_RST;
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end

endmodule

`default_nettype wire
